// ===== verilog/sleep_retention_pkg.sv
// constants and types for the sleep-state sequencer
//
// Notes on behaviour
// - sleep removes core-domain power, processor core included, battery rail only
// - processor RAM is marked invalid after every sleep period
// - leaving sleep always restarts the core at the reset vector
// - temperature ADC, supply ADC, clock and LCD stay powered, each enable kept
// - sleep lasts until an enabled or nonmaskable wake event arrives
// - four byte scratch registers keep contents through sleep
// - listed configuration registers are retained through sleep
// - temperature change wakes device unless temperature measurement disabled
// - supply ADC result sets flag bit 3 with supply measurement on; power event vector rises on it only with enable bit 3 set
// - supply ADC wake suppressed when enable bit 3 is clear
// - main supply restoration always wakes and sets flag bit 7
// - peripheral config bit 6 shows switched rail on main supply
// - non-supply wake resumes in battery run state at reset vector
package sleep_retention_pkg;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [7:0] ADDR_POWER_EVENT_ENABLE = 8'hEC;
  localparam logic [7:0] ADDR_TEMP_SUPPLY_DELTA  = 8'hF3;
  localparam logic [7:0] ADDR_PERIPHERAL_CONFIG  = 8'hF4;
  localparam logic [7:0] ADDR_POWER_EVENT_FLAGS  = 8'hF8;
  localparam logic [7:0] ADDR_SCRATCH_A          = 8'hFB;
  localparam logic [7:0] ADDR_SCRATCH_B          = 8'hFC;
  localparam logic [7:0] ADDR_SCRATCH_C          = 8'hFD;
  localparam logic [7:0] ADDR_SCRATCH_D          = 8'hFE;
  localparam logic [7:0] ADDR_POWER_CONTROL      = 8'hC5;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_SUPPLY_ADC      = 3;
  localparam int BIT_SUPPLY_RESTORED = 7;
  localparam int BIT_RAIL_ON_MAIN    = 6;
  localparam int BIT_SLEEP_REQUEST   = 4;
  localparam int BIT_TEMP_MEAS_EN    = 0;
  localparam int BIT_SUPPLY_MEAS_EN  = 1;
  localparam int BIT_CLOCK_EN        = 2;
  localparam int BIT_LCD_EN          = 3;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] RST_DELTA  = 8'h03;
  localparam logic [3:0] RST_PERIPHERAL_CONFIG = 4'hF;

  typedef enum logic [1:0] {
    NORMAL_RUN,
    BATTERY_RUN,
    SLEEP
  } power_state_e;

  // power switches toward the domains
  typedef struct packed {
    logic core_power_en;
    logic core_reset;
    logic ram_valid;
    logic temp_adc_en;
    logic supply_adc_en;
    logic clock_cal_en;
    logic lcd_en;
  } power_ctl_s;

  typedef logic [7:0] byte_t;

endpackage

// ===== verilog/sleep_mode_retention_wakeup.sv
// sleep-state sequencer with retained registers and wake-up logic
`timescale 1ns/100ps
module sleep_mode_retention_wakeup
  import sleep_retention_pkg::*;
(
  input  wire logic       CLK_SYS,
  input  wire logic       SYS_RST,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  input  wire logic       RAIL_ON_MAIN,
  input  wire logic       TEMP_CHANGE,
  input  wire logic       SUPPLY_ADC_DONE,
  output power_ctl_s      POWER_CTL,
  output logic            POWER_EVENT_VECTOR,
  output logic            WAKE_REQUEST,
  output logic      [1:0] POWER_STATE
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] rail_sync_reg;
  logic [1:0] temp_sync_reg;
  logic [1:0] sadc_sync_reg;
  logic       rail_prev_reg;
  logic       temp_prev_reg;
  logic       sadc_prev_reg;

  // rail starts high to match normal run, so reset raises no false restore
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rail_sync_reg <= '1;
      temp_sync_reg <= 2'h0;
      sadc_sync_reg <= 2'h0;
    end else begin
      rail_sync_reg <= {rail_sync_reg[0], RAIL_ON_MAIN};
      temp_sync_reg <= {temp_sync_reg[0], TEMP_CHANGE};
      sadc_sync_reg <= {sadc_sync_reg[0], SUPPLY_ADC_DONE};
    end
  end

  // previous levels for edge detect; only the second flop feeds them
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rail_prev_reg <= 1'b1;
      temp_prev_reg <= 1'b0;
      sadc_prev_reg <= 1'b0;
    end else begin
      rail_prev_reg <= rail_sync_reg[1];
      temp_prev_reg <= temp_sync_reg[1];
      sadc_prev_reg <= sadc_sync_reg[1];
    end
  end

  logic rail_on_main;
  logic supply_restored_event;
  logic temp_event;
  logic supply_adc_event;

  assign rail_on_main          = rail_sync_reg[1];
  assign supply_restored_event = rail_sync_reg[1] & ~rail_prev_reg;
  assign temp_event            = temp_sync_reg[1] & ~temp_prev_reg;
  assign supply_adc_event      = sadc_sync_reg[1] & ~sadc_prev_reg;

  // ****************************************
  // register file
  // ****************************************
  // retained set sits on the always-on domain, so only SYS_RST clears it
  byte_t power_event_enable_reg;
  byte_t temp_supply_delta_reg;
  logic [3:0] peripheral_config_ctl_reg;
  byte_t scratch_reg [4];
  logic  supply_adc_flag_reg;
  logic  supply_restored_flag_reg;
  power_state_e state_reg;
  power_state_e state_next;

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = REG_WR && (REG_ADDR == a);
  endfunction

  function automatic logic scratch_hit(input logic [7:0] a);
    scratch_hit = (a >= ADDR_SCRATCH_A) && (a <= ADDR_SCRATCH_D);
  endfunction

  // a sensor counts only with its delta check and its power enable both set
  function automatic logic meas_on(input byte_t      delta,
                                   input logic [3:0] enables,
                                   input int         b);
    meas_on = delta[b] & enables[b];
  endfunction

  // slot index only meaningful while scratch_hit is true
  logic [1:0] scratch_idx;
  assign scratch_idx = 2'(REG_ADDR - ADDR_SCRATCH_A);

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      power_event_enable_reg <= RST_BYTE;
    end else if (wr_hit(ADDR_POWER_EVENT_ENABLE)) begin
      power_event_enable_reg <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      temp_supply_delta_reg <= RST_DELTA;
    end else if (wr_hit(ADDR_TEMP_SUPPLY_DELTA)) begin
      temp_supply_delta_reg <= REG_WDATA;
    end
  end

  // only the four enables are stored; the rail bit is live status
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      peripheral_config_ctl_reg <= RST_PERIPHERAL_CONFIG;
    end else if (wr_hit(ADDR_PERIPHERAL_CONFIG)) begin
      peripheral_config_ctl_reg <= REG_WDATA[3:0];
    end
  end

  // scratch bytes never cleared by sleep entry or wake
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      for (int i = 0; i < 4; i++) begin
        scratch_reg[i] <= RST_BYTE;
      end
    end else if (REG_WR && scratch_hit(REG_ADDR)) begin
      scratch_reg[scratch_idx] <= REG_WDATA;
    end
  end

  // ****************************************
  // event flags
  // ****************************************
  // write one to clear; a same-cycle event wins over the clear
  // always_comb, not assign: wr_hit reads bus signals behind its argument
  logic flags_wr;
  always_comb begin
    flags_wr = wr_hit(ADDR_POWER_EVENT_FLAGS);
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      supply_adc_flag_reg <= 1'b0;
    end else if (supply_adc_event
                 && meas_on(temp_supply_delta_reg, peripheral_config_ctl_reg,
                            BIT_SUPPLY_MEAS_EN)) begin
      supply_adc_flag_reg <= 1'b1;
    end else if (flags_wr && REG_WDATA[BIT_SUPPLY_ADC]) begin
      supply_adc_flag_reg <= 1'b0;
    end
  end

  // restore flag has no enable: it is never masked
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      supply_restored_flag_reg <= 1'b0;
    end else if (supply_restored_event) begin
      supply_restored_flag_reg <= 1'b1;
    end else if (flags_wr && REG_WDATA[BIT_SUPPLY_RESTORED]) begin
      supply_restored_flag_reg <= 1'b0;
    end
  end

  // ****************************************
  // wake-up request
  // ****************************************
  // wake sources that the enables have not masked
  logic temp_wake;
  logic adc_wake;
  assign temp_wake = temp_event
                   & meas_on(temp_supply_delta_reg, peripheral_config_ctl_reg,
                             BIT_TEMP_MEAS_EN);
  assign adc_wake  = supply_adc_flag_reg
                   & power_event_enable_reg[BIT_SUPPLY_ADC];

  // pending restore flag stays in the request, so no rail return is lost
  assign WAKE_REQUEST = supply_restored_event | supply_restored_flag_reg
                      | adc_wake | temp_wake;

  assign POWER_EVENT_VECTOR = adc_wake | supply_restored_flag_reg;

  // ****************************************
  // power state machine
  // ****************************************
  logic sleep_req;
  always_comb begin
    sleep_req = wr_hit(ADDR_POWER_CONTROL) && REG_WDATA[BIT_SLEEP_REQUEST];
  end

  // battery run is the only way in; any supply return goes to normal run
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      NORMAL_RUN: begin
        if (!rail_on_main) begin
          state_next = BATTERY_RUN;
        end
      end
      BATTERY_RUN: begin
        if (rail_on_main) begin
          state_next = NORMAL_RUN;
        end else if (sleep_req) begin
          state_next = SLEEP;
        end
      end
      SLEEP: begin
        // held here with no timeout until a wake source fires
        if (supply_restored_event || rail_on_main) begin
          state_next = NORMAL_RUN;
        end else if (WAKE_REQUEST) begin
          state_next = BATTERY_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state_reg <= NORMAL_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // core domain control
  // ****************************************
  // ram validity dropped on sleep; firmware sees it clear after wake
  logic ram_valid_reg;
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ram_valid_reg <= 1'b1;
    end else if (state_reg == SLEEP) begin
      ram_valid_reg <= 1'b0;
    end else if (wr_hit(ADDR_POWER_CONTROL) && !REG_WDATA[BIT_SLEEP_REQUEST])
    begin
      ram_valid_reg <= 1'b1;
    end
  end

  // core reset follows sleep one cycle late, so it is set from the second sleep cycle to one cycle after wake
  logic core_reset_reg;
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      core_reset_reg <= 1'b1;
    end else begin
      core_reset_reg <= (state_reg == SLEEP);
    end
  end

  // sleep cuts the core rail; always-on enables pass through untouched
  always_comb begin
    POWER_CTL.core_power_en = (state_reg != SLEEP);
    POWER_CTL.core_reset    = core_reset_reg;
    POWER_CTL.ram_valid     = ram_valid_reg;
    POWER_CTL.temp_adc_en   = peripheral_config_ctl_reg[BIT_TEMP_MEAS_EN];
    POWER_CTL.supply_adc_en = peripheral_config_ctl_reg[BIT_SUPPLY_MEAS_EN];
    POWER_CTL.clock_cal_en  = peripheral_config_ctl_reg[BIT_CLOCK_EN];
    POWER_CTL.lcd_en        = peripheral_config_ctl_reg[BIT_LCD_EN];
  end

  assign POWER_STATE = state_reg;

  // ****************************************
  // read path
  // ****************************************
  // write-only power control and unmapped addresses read as zero
  byte_t rdata_next;
  always_comb begin
    rdata_next = RST_BYTE;
    if (scratch_hit(REG_ADDR)) begin
      rdata_next = scratch_reg[scratch_idx];
    end else begin
      unique case (REG_ADDR)
        ADDR_POWER_EVENT_ENABLE: rdata_next = power_event_enable_reg;
        ADDR_TEMP_SUPPLY_DELTA:  rdata_next = temp_supply_delta_reg;
        ADDR_PERIPHERAL_CONFIG: begin
          rdata_next[3:0] = peripheral_config_ctl_reg;
          rdata_next[BIT_RAIL_ON_MAIN] = rail_on_main;
        end
        ADDR_POWER_EVENT_FLAGS: begin
          rdata_next[BIT_SUPPLY_ADC]      = supply_adc_flag_reg;
          rdata_next[BIT_SUPPLY_RESTORED] = supply_restored_flag_reg;
        end
        default: rdata_next = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      REG_RDATA <= RST_BYTE;
    end else if (REG_RD) begin
      REG_RDATA <= rdata_next;
    end
  end

endmodule

// ===== testbench/sleep_mode_retention_wakeup_props.sv
// checker for sleep sequencing at the top-level ports
`timescale 1ns/100ps
module sleep_mode_retention_wakeup_props
  import sleep_retention_pkg::*;
(
  input wire logic       CLK_SYS,
  input wire logic       SYS_RST,
  input wire logic       RAIL_ON_MAIN,
  input wire power_ctl_s POWER_CTL,
  input wire logic       POWER_EVENT_VECTOR,
  input wire logic       WAKE_REQUEST,
  input wire logic [1:0] POWER_STATE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  property p_core_off;
    POWER_STATE == 2'h2 |-> !POWER_CTL.core_power_en;
  endproperty
  a_core_off: assert property (p_core_off)
    else $error("core powered in sleep");
  property p_enter;
    POWER_STATE == 2'h2 && $past(POWER_STATE) != 2'h2
      |-> $past(POWER_STATE) == 2'h1;
  endproperty
  a_enter: assert property (p_enter)
    else $error("sleep entered from non-battery state");
  property p_ram;
    POWER_STATE == 2'h2 && $past(POWER_STATE) == 2'h2 |-> !POWER_CTL.ram_valid;
  endproperty
  a_ram: assert property (p_ram)
    else $error("ram valid while asleep");
  property p_restart;
    $past(POWER_STATE) == 2'h2 |-> POWER_CTL.core_reset;
  endproperty
  a_restart: assert property (p_restart)
    else $error("core left reset straight out of sleep");
  property p_stay;
    POWER_STATE == 2'h1 && $past(POWER_STATE) == 2'h2 |-> $past(WAKE_REQUEST);
  endproperty
  a_stay: assert property (p_stay)
    else $error("left sleep without a wake request");
  property p_leave;
    POWER_STATE == 2'h2 && WAKE_REQUEST |=> POWER_STATE != 2'h2;
  endproperty
  a_leave: assert property (p_leave)
    else $error("wake request ignored");
  property p_vector;
    POWER_EVENT_VECTOR |-> WAKE_REQUEST;
  endproperty
  a_vector: assert property (p_vector)
    else $error("event vector without wake request");
  property p_restore;
    RAIL_ON_MAIN [*4] |-> ##[0:2] POWER_STATE == 2'h0;
  endproperty
  a_restore: assert property (p_restore)
    else $error("main supply back but not in normal run");
  property p_battery;
    !RAIL_ON_MAIN [*4] ##0 (POWER_STATE == 2'h2 && WAKE_REQUEST)
      |=> POWER_STATE == 2'h1;
  endproperty
  a_battery: assert property (p_battery)
    else $error("battery wake did not resume in battery run");
endmodule

bind sleep_mode_retention_wakeup sleep_mode_retention_wakeup_props u_props (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .RAIL_ON_MAIN(RAIL_ON_MAIN),
  .POWER_CTL(POWER_CTL), .POWER_EVENT_VECTOR(POWER_EVENT_VECTOR),
  .WAKE_REQUEST(WAKE_REQUEST), .POWER_STATE(POWER_STATE));

// ===== testbench/always_on_model.sv
// always-on supply and sensor pins seen by the sequencer
`timescale 1ns/100ps
module always_on_model (
  input  wire logic clk,
  output logic      rail_on_main,
  output logic      temp_change,
  output logic      supply_adc_done
);
  initial begin
    rail_on_main = 1'b1;
    temp_change = 1'b0;
    supply_adc_done = 1'b0;
  end
  task automatic set_rail(input logic v);
    @(negedge clk);
    rail_on_main = v;
  endtask
  // two cycles high so the two-flop sync never misses it
  task automatic pulse_temp();
    @(negedge clk);
    temp_change = 1'b1;
    repeat (2) @(negedge clk);
    temp_change = 1'b0;
  endtask
  task automatic pulse_adc();
    @(negedge clk);
    supply_adc_done = 1'b1;
    repeat (2) @(negedge clk);
    supply_adc_done = 1'b0;
  endtask
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the sleep-state sequencer
`timescale 1ns/100ps
module tb_top;
  import sleep_retention_pkg::*;
  logic       clk_sys = 1'b0;
  logic       sys_rst, reg_wr, reg_rd, rail, temp, adc, vec, wake;
  byte_t      reg_addr, reg_wdata, reg_rdata;
  power_ctl_s pctl;
  logic [1:0] state;
  int         errors = 0;
  int         checks_done = 0;
  int         cycles = 0;
  always #10 clk_sys = ~clk_sys;
  sleep_mode_retention_wakeup u_sleep_mode_retention_wakeup (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .RAIL_ON_MAIN(rail), .TEMP_CHANGE(temp),
    .SUPPLY_ADC_DONE(adc), .POWER_CTL(pctl), .POWER_EVENT_VECTOR(vec),
    .WAKE_REQUEST(wake), .POWER_STATE(state));
  always_on_model u_always_on_model (
    .clk(clk_sys), .rail_on_main(rail), .temp_change(temp),
    .supply_adc_done(adc));
  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic summarize();
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input byte_t a, input byte_t d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input byte_t a, input byte_t m, input byte_t exp);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata & m, exp);
  endtask
  // bounded wait, then the state itself is the comparison
  task automatic wait_st(input logic [1:0] e);
    for (int i = 0; i < 12 && state !== e; i++) @(negedge clk_sys);
    chk({6'h00, state}, {6'h00, e});
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    rd(ADDR_POWER_EVENT_ENABLE, 8'hFF, RST_BYTE);
    rd(ADDR_TEMP_SUPPLY_DELTA, 8'hFF, RST_DELTA);
    rd(ADDR_PERIPHERAL_CONFIG, 8'h4F, {4'h4, RST_PERIPHERAL_CONFIG});
    rd(ADDR_POWER_EVENT_FLAGS, 8'hFF, 8'h00);
    wr(8'h80, 8'hFF);
    rd(8'h80, 8'hFF, 8'h00);
    for (int i = 0; i < 4; i++) wr(ADDR_SCRATCH_A + 8'(i), 8'hA0 + 8'(i));
    u_always_on_model.set_rail(1'b0);
    wait_st(2'h1);
    rd(ADDR_PERIPHERAL_CONFIG, 8'h40, 8'h00);
    wr(ADDR_TEMP_SUPPLY_DELTA, 8'h02);
    wr(ADDR_POWER_CONTROL, 8'h10);
    wait_st(2'h2);
    @(negedge clk_sys);
    chk({7'h00, pctl.core_power_en}, 8'h00);
    chk({7'h00, pctl.ram_valid}, 8'h00);
    chk({4'h0, pctl.temp_adc_en, pctl.supply_adc_en, pctl.clock_cal_en,
         pctl.lcd_en}, 8'h0F);
    u_always_on_model.pulse_temp();
    repeat (8) @(negedge clk_sys);
    chk({6'h00, state}, 8'h02);
    u_always_on_model.pulse_adc();
    repeat (8) @(negedge clk_sys);
    chk({6'h00, state}, 8'h02);
    u_always_on_model.set_rail(1'b1);
    wait_st(2'h0);
    rd(ADDR_POWER_EVENT_FLAGS, 8'hFF, 8'h88);
    rd(ADDR_PERIPHERAL_CONFIG, 8'h40, 8'h40);
    wr(ADDR_POWER_EVENT_FLAGS, 8'h88);
    rd(ADDR_POWER_EVENT_FLAGS, 8'hFF, 8'h00);
    wr(ADDR_POWER_CONTROL, 8'h00);
    chk({7'h00, pctl.ram_valid}, 8'h01);
    for (int i = 0; i < 4; i++)
      rd(ADDR_SCRATCH_A + 8'(i), 8'hFF, 8'hA0 + 8'(i));
    rd(ADDR_TEMP_SUPPLY_DELTA, 8'hFF, 8'h02);
    u_always_on_model.set_rail(1'b0);
    wait_st(2'h1);
    wr(ADDR_TEMP_SUPPLY_DELTA, 8'h03);
    wr(ADDR_POWER_EVENT_ENABLE, 8'h08);
    wr(ADDR_POWER_CONTROL, 8'h10);
    wait_st(2'h2);
    u_always_on_model.pulse_temp();
    wait_st(2'h1);
    chk({7'h00, pctl.core_reset}, 8'h01);
    chk({7'h00, pctl.ram_valid}, 8'h00);
    wr(ADDR_POWER_CONTROL, 8'h10);
    wait_st(2'h2);
    u_always_on_model.pulse_adc();
    wait_st(2'h1);
    chk({7'h00, vec}, 8'h01);
    rd(ADDR_POWER_EVENT_FLAGS, 8'hFF, 8'h08);
    wr(ADDR_POWER_EVENT_FLAGS, 8'h08);
    chk({7'h00, vec}, 8'h00);
    summarize();
  end
endmodule
